// [core/digital_input_latch_unit.sv]
// Purpose: Twenty conditioned digital inputs with fast position latches
// Assumes: Pins are asynchronous; axis positions are on clk_i
// Notes:   Registers on a plain port, read data one cycle later
//
// Notes on behaviour
// - Twenty general inputs 0..19, each usable by any axis.
// - Three groups, each with its own polarity setting.
// - Inputs 0..3 form the first polarity group.
// - Inputs 4..11 form group two, sampled at 1 kHz.
// - Inputs 12..19 as 4..11 but in group three.
// - Per input: programmable active level, level or edge detection.
// - Software reads raw and active state of every input.
// - Any input can drive home, limits, stop or fault of an axis.
// - Inputs 0..3 latch positions of any selected axes in hardware.
// - Fast input to position capture takes at most 1 us.
// - Fast activation starts follow-on latch actions and tells software.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`include "dil_params.svh"
module digital_input_latch_unit #(
  parameter int NAXES    = 4,
  parameter int POS_W    = 32,
  parameter int SCAN_DIV = `DIL_SCAN_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  input  wire logic [`DIL_NPIN-1:0]        pin_i,
  input  wire logic [NAXES-1:0][POS_W-1:0] axis_pos_i,
  input  wire dil_pkg::reg_req_t           bus_i,
  output logic      [`DIL_DW-1:0]          rdata_o,
  output logic                             irq_o,
  output logic      [`DIL_NFAST-1:0]       latch_evt_o,
  output dil_pkg::role_t [NAXES-1:0]       role_o
);
  import dil_pkg::*;

  localparam int NPIN    = `DIL_NPIN;
  localparam int NFAST   = `DIL_NFAST;
  localparam int SW      = $clog2(SCAN_DIV + 1);
  localparam int LAT_CYC = `DIL_LATCH_CYC;

  typedef struct packed {
    logic [SW-1:0]                    div;
    logic [NPIN-1:0]                  raw;
    logic [NPIN-1:0]                  act_prev;
    logic [2:0]                       pol;
    logic [NPIN-1:0]                  edge_mode;
    logic [NPIN-1:0]                  inv;
    logic [NPIN-1:0]                  status;
    logic [NPIN-1:0]                  mask;
    logic [NFAST-1:0]                 fast_en;
    logic [NFAST-1:0][NAXES-1:0]      lsel;
    logic [NAXES-1:0][`DIL_ROLE_W-1:0] rsel;
    logic [NAXES-1:0][POS_W-1:0]      cap;
    logic [`DIL_DW-1:0]               rdata;
    logic                             irq;
    logic [NFAST-1:0]                 levt;
    role_t [NAXES-1:0]                role;
  } state_t;

  state_t           s_q;
  state_t           s_d;
  logic [NPIN-1:0]  sync_w;
  logic [NPIN-1:0]  act;
  logic [NPIN-1:0]  rise;
  logic [NPIN-1:0]  ev;
  logic [NFAST-1:0] trig;
  logic             tick;
  logic             rd_stat;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Expand the three group polarities onto the pins
  function automatic logic [NPIN-1:0] pol_vec(input logic [2:0] p);
    logic [NPIN-1:0] v;
    v = '0;
    for (int i = 0; i < NPIN; i++) begin
      if (i < `DIL_G1_LO) begin
        v[i] = p[0];
      end else if (i < `DIL_G2_LO) begin
        v[i] = p[1];
      end else begin
        v[i] = p[2];
      end
    end
    return v;
  endfunction

  // Active state of a selected pin; out-of-range select means unused
  function automatic logic pick(input logic [NPIN-1:0] v,
                                input logic [`DIL_SEL_W-1:0] s);
    logic r;
    r = 1'b0;
    if (int'(s) < NPIN) begin
      r = v[s];
    end
    return r;
  endfunction

  // Word index within an array region, or -1 when outside it
  function automatic int region(input logic [`DIL_AW-1:0] a,
                                input logic [`DIL_AW-1:0] base,
                                input int n);
    int r;
    r = -1;
    if (a >= base && a[1:0] == 2'b00 &&
        int'(a - base) < 4 * n) begin
      r = int'(a - base) / 4;
    end
    return r;
  endfunction

  // Fast pins whose latch selects include one axis
  function automatic logic [NFAST-1:0] lsel_col(
    input logic [NFAST-1:0][NAXES-1:0] l,
    input int                          a);
    logic [NFAST-1:0] c;
    c = '0;
    for (int k = 0; k < NFAST; k++) begin
      c[k] = l[k][a];
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  dil_sync #(
    .W (NPIN)
  ) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (pin_i),
    .q_o    (sync_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    int li;
    int ri;
    int ci;
    li      = region(bus_i.addr, `DIL_LSEL_OFS, NFAST);
    ri      = region(bus_i.addr, `DIL_ROLE_OFS, NAXES);
    ci      = region(bus_i.addr, `DIL_CAP_OFS, NAXES);
    s_d     = s_q;

    // Scan divider for the slow groups
    tick    = (s_q.div == SW'(SCAN_DIV - 1));
    s_d.div = tick ? '0 : s_q.div + 1'b1;

    // Fast pins follow every cycle; slow ones only on the scan tick
    s_d.raw[NFAST-1:0] = sync_w[NFAST-1:0];
    if (tick) begin
      s_d.raw[NPIN-1:NFAST] = sync_w[NPIN-1:NFAST];
    end

    // Group polarity and per-pin level combine into the active state
    act  = s_q.raw ^ pol_vec(s_q.pol) ^ s_q.inv;
    rise = act & ~s_q.act_prev;
    s_d.act_prev = act;
    ev   = (s_q.edge_mode & rise) | (~s_q.edge_mode & act);
    trig = s_q.fast_en & rise[NFAST-1:0];

    // Captures of all selected axes load in the same cycle
    for (int a = 0; a < NAXES; a++) begin
      for (int k = 0; k < NFAST; k++) begin
        if (trig[k] && s_q.lsel[k][a]) begin
          s_d.cap[a] = axis_pos_i[a];
        end
      end
    end
    s_d.levt = trig;

    // Role routing
    for (int a = 0; a < NAXES; a++) begin
      s_d.role[a].home      = pick(act,
        s_q.rsel[a][`DIL_HOME_LSB +: `DIL_SEL_W]);
      s_d.role[a].fwd_limit = pick(act,
        s_q.rsel[a][`DIL_FWD_LSB +: `DIL_SEL_W]);
      s_d.role[a].rev_limit = pick(act,
        s_q.rsel[a][`DIL_REV_LSB +: `DIL_SEL_W]);
      s_d.role[a].stop      = pick(act,
        s_q.rsel[a][`DIL_STOP_LSB +: `DIL_SEL_W]);
      s_d.role[a].fault     = pick(act,
        s_q.rsel[a][`DIL_FAULT_LSB +: `DIL_SEL_W]);
    end

    // Register writes
    if (bus_i.we) begin
      case (bus_i.addr)
        `DIL_POL_OFS:  s_d.pol       = bus_i.wdata[2:0];
        `DIL_EDGE_OFS: s_d.edge_mode = bus_i.wdata[NPIN-1:0];
        `DIL_INV_OFS:  s_d.inv       = bus_i.wdata[NPIN-1:0];
        `DIL_MASK_OFS: s_d.mask      = bus_i.wdata[NPIN-1:0];
        `DIL_FEN_OFS:  s_d.fast_en   = bus_i.wdata[NFAST-1:0];
        default: begin
          if (li >= 0) begin
            s_d.lsel[li] = bus_i.wdata[NAXES-1:0];
          end
          if (ri >= 0) begin
            s_d.rsel[ri] = bus_i.wdata[`DIL_ROLE_W-1:0];
          end
        end
      endcase
    end

    // Register reads; status clears on read but a new event wins
    rd_stat   = bus_i.re && (bus_i.addr == `DIL_STAT_OFS);
    s_d.rdata = '0;
    if (bus_i.re) begin
      case (bus_i.addr)
        `DIL_POL_OFS:  s_d.rdata = `DIL_DW'(s_q.pol);
        `DIL_EDGE_OFS: s_d.rdata = `DIL_DW'(s_q.edge_mode);
        `DIL_INV_OFS:  s_d.rdata = `DIL_DW'(s_q.inv);
        `DIL_RAW_OFS:  s_d.rdata = `DIL_DW'(s_q.raw);
        `DIL_ACT_OFS:  s_d.rdata = `DIL_DW'(act);
        `DIL_STAT_OFS: s_d.rdata = `DIL_DW'(s_q.status);
        `DIL_MASK_OFS: s_d.rdata = `DIL_DW'(s_q.mask);
        `DIL_FEN_OFS:  s_d.rdata = `DIL_DW'(s_q.fast_en);
        default: begin
          if (li >= 0) begin
            s_d.rdata = `DIL_DW'(s_q.lsel[li]);
          end
          if (ri >= 0) begin
            s_d.rdata = `DIL_DW'(s_q.rsel[ri]);
          end
          if (ci >= 0) begin
            s_d.rdata = `DIL_DW'(s_q.cap[ci]);
          end
        end
      endcase
    end
    s_d.status = (rd_stat ? '0 : s_q.status) | ev;
    s_d.irq    = |(s_d.status & s_d.mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q      <= '0;
      s_q.rsel <= {NAXES{`DIL_ROLE_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o     = s_q.rdata;
  assign irq_o       = s_q.irq;
  assign latch_evt_o = s_q.levt;
  assign role_o      = s_q.role;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic [SW-1:0] gap_q;
  logic          seen_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= tick ? '0 : gap_q + 1'b1;
      seen_q <= seen_q | tick;
    end
  end

  sequence pin_held(k);
    $rose(pin_i[k]) ##1 pin_i[k] [*4];
  endsequence

  sequence fast_fire(k);
    trig[k] ##1 latch_evt_o[k];
  endsequence

  a_scan_period: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tick && seen_q |-> gap_q == SW'(SCAN_DIV - 1))
    else $error("scan tick spacing wrong");

  a_slow_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !tick |=> $stable(s_q.raw[NPIN-1:NFAST]))
    else $error("slow input changed between scans");

  a_pin_reach: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pin_held(0) |-> s_q.raw[0])
    else $error("fast pin not seen within latency");

  a_fire_status: assert property (@(posedge clk_i) disable iff (!rstn_i)
    fast_fire(1) |-> s_q.status[1])
    else $error("fast activation not flagged");

  a_latch_window: assert property (@(posedge clk_i) disable iff (!rstn_i)
    trig[0] |-> ##[1:LAT_CYC] latch_evt_o[0])
    else $error("latch event late");

  a_edge_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.status[5] && !rd_stat |=> s_q.status[5])
    else $error("edge flag lost");

  a_irq_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_o == |(s_q.status & s_q.mask))
    else $error("interrupt does not follow status");

  a_raw_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bus_i.re && bus_i.addr == `DIL_RAW_OFS
    |=> rdata_o == `DIL_DW'($past(s_q.raw)))
    else $error("raw read data wrong");

  a_group_pol: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.pol[1] && s_q.inv[6] == 1'b0 |-> act[6] == !s_q.raw[6])
    else $error("group polarity not applied");

  a_read_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_stat |=> s_q.status == $past(ev))
    else $error("status clear lost a new event");

  a_evt_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i)
    latch_evt_o[0] |=> !latch_evt_o[0])
    else $error("latch event longer than one cycle");

  a_level_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !s_q.edge_mode[13] && act[13] |=> s_q.status[13])
    else $error("level input did not set status");

  generate
    for (genvar a = 0; a < NAXES; a++) begin : g_chk
      a_cap_load: assert property (@(posedge clk_i)
        disable iff (!rstn_i)
        |(trig & lsel_col(s_q.lsel, a))
        |=> s_q.cap[a] == $past(axis_pos_i[a]))
        else $error("capture not loaded");
      a_home_route: assert property (@(posedge clk_i)
        disable iff (!rstn_i)
        s_q.rsel[a][`DIL_SEL_W-1:0] == '0
        |=> role_o[a].home == $past(act[0]))
        else $error("home role wrong");
    end
  endgenerate

endmodule // digital_input_latch_unit

// [core/dil_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit byte address, 32-bit register data, 20 MHz clock
// Notes:   Included by the package and by the unit
`ifndef DIL_PARAMS_SVH
`define DIL_PARAMS_SVH

`define DIL_NPIN        20
`define DIL_NFAST       4
`define DIL_G1_LO       4
`define DIL_G2_LO       12
`define DIL_AW          8
`define DIL_DW          32

`define DIL_POL_OFS     8'h00
`define DIL_EDGE_OFS    8'h04
`define DIL_INV_OFS     8'h08
`define DIL_RAW_OFS     8'h0C
`define DIL_ACT_OFS     8'h10
`define DIL_STAT_OFS    8'h14
`define DIL_MASK_OFS    8'h18
`define DIL_FEN_OFS     8'h1C
`define DIL_LSEL_OFS    8'h20
`define DIL_ROLE_OFS    8'h40
`define DIL_CAP_OFS     8'h80

`define DIL_SEL_W       5
`define DIL_HOME_LSB    0
`define DIL_FWD_LSB     5
`define DIL_REV_LSB     10
`define DIL_STOP_LSB    15
`define DIL_FAULT_LSB   20
`define DIL_ROLE_W      25
`define DIL_ROLE_RST    25'h1FF_FFFF

`define DIL_CLK_NS      50
`define DIL_SCAN_NS     1000000
`define DIL_SCAN_CYC    (`DIL_SCAN_NS / `DIL_CLK_NS)
`define DIL_LATCH_NS    1000
`define DIL_LATCH_CYC   (`DIL_LATCH_NS / `DIL_CLK_NS)

`endif

// [core/dil_pkg.sv]
// Purpose: Types shared by the digital input latch unit
// Assumes: dil_params.svh holds the numbers
// Notes:   Register port request and per-axis role outputs
`include "dil_params.svh"
package dil_pkg;

  typedef struct packed {
    logic                   we;
    logic                   re;
    logic [`DIL_AW-1:0]     addr;
    logic [`DIL_DW-1:0]     wdata;
  } reg_req_t;

  typedef struct packed {
    logic home;
    logic fwd_limit;
    logic rev_limit;
    logic stop;
    logic fault;
  } role_t;

endpackage

// [core/dil_sync.sv]
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Inputs are slow levels relative to clk_i
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ns
module dil_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // dil_sync

// [bench/field_model.sv]
// Purpose: Field switches, sensors and drive outputs on the inputs
// Assumes: Clean levels, changed just after a rising clock edge
// Notes:   The bench calls the tasks below
`timescale 1ns/1ns
`include "dil_params.svh"
module field_model (
  input  wire logic                 clk_i,
  output logic      [`DIL_NPIN-1:0] pin_o
);
  initial pin_o = '0;
  ////////////////////////////////////////////////////////////////////
  // One clean transition per call, never a bounce
  task automatic set(input int i, input logic v);
    @(posedge clk_i);
    pin_o[i] <= v;
  endtask
  // Trigger pulse held for n clock cycles, then released
  task automatic pulse(input int i, input int n);
    set(i, 1'b1);
    repeat (n) @(posedge clk_i);
    pin_o[i] <= 1'b0;
  endtask
  task automatic put(input logic [`DIL_NPIN-1:0] v);
    @(posedge clk_i);
    pin_o <= v;
  endtask
endmodule // field_model

// [bench/tb.sv]
// Purpose: Self-checking bench of the digital input latch unit
// Assumes: Short scan divider; register port with one-cycle strobes
// Notes:   One task per scenario
`timescale 1ns/1ns
`include "dil_params.svh"
module tb;
  import dil_pkg::*;
  localparam int NAX  = 4;
  localparam int SDIV = 10;
  localparam int SW   = 2 * SDIV + 4;
  logic                       clk_i;
  logic                       rstn_i;
  logic [`DIL_NPIN-1:0]       pin_i;
  logic [NAX-1:0][31:0]       axis_pos_i;
  reg_req_t                   bus_i;
  logic [31:0]                rdata_o;
  logic                       irq_o;
  logic [3:0]                 latch_evt_o;
  role_t [NAX-1:0]            role_o;
  logic [31:0]                ec [NAX];
  logic [31:0]                d;
  int                         mismatches;
  int                         compares;

  digital_input_latch_unit #(
    .NAXES(NAX), .POS_W(32), .SCAN_DIV(SDIV)
  ) digital_input_latch_unit_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(pin_i),
    .axis_pos_i(axis_pos_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .latch_evt_o(latch_evt_o), .role_o(role_o)
  );
  field_model field_model_inst (.clk_i(clk_i), .pin_o(pin_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    bus_i <= '{we: 1'b1, re: 1'b0, addr: a, wdata: v};
    @(posedge clk_i);
    bus_i.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    bus_i <= '{we: 1'b0, re: 1'b1, addr: a, wdata: '0};
    @(posedge clk_i);
    bus_i.re <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
    rd(a, d);
    chk(n, d, e);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("role_o", role_o, '0);
    rchk("pol", `DIL_POL_OFS, '0);
    rchk("edge", `DIL_EDGE_OFS, '0);
    rchk("role", `DIL_ROLE_OFS + 8'h04, 32'h01FF_FFFF);
    wr(`DIL_RAW_OFS, 32'hFFFF_FFFF);
    wr(8'hFC, 32'hFFFF_FFFF);
    rchk("raw_ro", `DIL_RAW_OFS, '0);
    rchk("unmapped", 8'hFC, '0);
  endtask
  task automatic t_groups;
    logic [19:0] p;
    logic [19:0] gm;
    p = 20'hA_5C3A;
    field_model_inst.put(p);
    tick(SW);
    rchk("raw", `DIL_RAW_OFS, {12'h000, p});
    for (int g = 0; g < 3; g++) begin
      gm = (g == 0) ? 20'h0_000F : (g == 1) ? 20'h0_0FF0 : 20'hF_F000;
      wr(`DIL_POL_OFS, 32'h0000_0001 << g);
      tick(SW);
      rchk("act", `DIL_ACT_OFS, {12'h000, p ^ gm});
    end
    wr(`DIL_POL_OFS, '0);
    wr(`DIL_INV_OFS, 32'h0000_0011);
    tick(SW);
    rchk("act_inv", `DIL_ACT_OFS, {12'h000, p ^ 20'h0_0011});
    wr(`DIL_INV_OFS, '0);
    field_model_inst.put('0);
    tick(SW);
    rd(`DIL_STAT_OFS, d);
  endtask
  task automatic t_fast;
    logic [3:0] sel;
    int n;
    wr(`DIL_FEN_OFS, 32'h0000_000F);
    wr(`DIL_MASK_OFS, 32'h0000_000F);
    for (int k = 0; k < 4; k++) begin
      sel = 4'h1 + 4'h4 * k[3:0];
      wr(`DIL_LSEL_OFS + 8'(4 * k), {28'h000_0000, sel});
      for (int a = 0; a < NAX; a++) begin
        axis_pos_i[a] <= 32'h0100_0000 * (a + 1) + k;
      end
      field_model_inst.set(k, 1'b1);
      n = 0;
      while (latch_evt_o[k] !== 1'b1 && n < `DIL_LATCH_CYC) begin
        @(posedge clk_i);
        #1 n++;
      end
      chk("latch_evt", latch_evt_o, 4'h1 << k);
      chk("irq", irq_o, 1'b1);
      for (int a = 0; a < NAX; a++) begin
        if (sel[a]) begin
          ec[a] = 32'h0100_0000 * (a + 1) + k;
        end
      end
      field_model_inst.set(k, 1'b0);
      axis_pos_i <= '1;
      for (int a = 0; a < NAX; a++)
        rchk("cap", `DIL_CAP_OFS + 8'(4 * a), ec[a]);
      rchk("status", `DIL_STAT_OFS, 32'h0000_0001 << k);
      tick(2);
      chk("irq_clr", irq_o, 1'b0);
    end
    wr(`DIL_FEN_OFS, '0);
    wr(`DIL_MASK_OFS, '0);
    field_model_inst.set(0, 1'b1);
    tick(8);
    chk("irq_masked", irq_o, 1'b0);
    rchk("cap_off", `DIL_CAP_OFS, ec[0]);
    field_model_inst.set(0, 1'b0);
    tick(4);
    rd(`DIL_STAT_OFS, d);
  endtask
  task automatic t_edge;
    wr(`DIL_EDGE_OFS, 32'h0000_0020);
    wr(`DIL_MASK_OFS, 32'h0000_2020);
    field_model_inst.pulse(5, SDIV + 2);
    tick(SDIV + 4);
    rchk("edge_set", `DIL_STAT_OFS, 32'h0000_0020);
    rchk("edge_clr", `DIL_STAT_OFS, '0);
    field_model_inst.set(13, 1'b1);
    tick(SW);
    rd(`DIL_STAT_OFS, d);
    tick(2);
    rchk("level_set", `DIL_STAT_OFS, 32'h0000_2000);
    chk("irq_lvl", irq_o, 1'b1);
    field_model_inst.set(13, 1'b0);
    tick(SW);
    rd(`DIL_STAT_OFS, d);
  endtask
  task automatic t_role;
    wr(`DIL_ROLE_OFS + 8'h04, {7'h00, 5'h1F, 5'h00, 5'h13, 5'h0C, 5'h04});
    field_model_inst.put(20'h8_0011);
    tick(SW);
    chk("role1", role_o[1], 32'h0000_0016);
    chk("role0", role_o[0], '0);
    wr(`DIL_ROLE_OFS, 32'h01FF_FFE0);
    tick(2);
    chk("role0_home", role_o[0], 32'h0000_0010);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("Compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    rstn_i = 1'b0;
    bus_i = '0;
    axis_pos_i = '0;
    mismatches = 0;
    compares = 0;
    for (int a = 0; a < NAX; a++) ec[a] = '0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset;
    t_groups;
    t_fast;
    t_edge;
    t_role;
    conclude();
  end
  // Whole run takes well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    conclude();
  end
endmodule // tb
